//--- iemb_mask_bank.sv
/*
 Interrupt enable mask bank: three 16-bit enable registers on an AXI4-Lite slave,
 gating per-source flag inputs into registered request outputs.
 Assumes flags and priorities come from logic on aclk; aresetn is synchronous, active low.
*/
`timescale 1ns/100ps
module iemb_mask_bank (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire iemb_pkg::iemb_axi_req_t axi_req,
   output      iemb_pkg::iemb_axi_rsp_t axi_rsp,
   input  wire iemb_pkg::iemb_vec_t     src_flag,
   input  wire iemb_pkg::iemb_prio_t    src_prio,
   output      iemb_pkg::iemb_vec_t     irq_req,
   output      iemb_pkg::iemb_vec_t     mask_out
);
   import iemb_pkg::*;

   iemb_state_t s_q;
   iemb_state_t s_d;

   logic [1:0] widx;
   logic [1:0] ridx;
   logic [REG_W-1:0] wbits;
   iemb_vec_t        en;

   // ----------------------------------------------------------------------
   // Per-source enables
   // ----------------------------------------------------------------------
   // Each source is placed by its own field constant. A position that no source owns can never
   // request, whatever the mask register holds, so a stray mask bit cannot raise a request.
   always_comb begin
      en = '0;
      en[0][DMA_CH1_DONE_EN]     = s_q.mask[0][DMA_CH1_DONE_EN];
      en[0][ADC_ONE_DONE_EN]     = s_q.mask[0][ADC_ONE_DONE_EN];
      en[0][UART_ONE_TX_EN]      = s_q.mask[0][UART_ONE_TX_EN];
      en[0][UART_ONE_RX_EN]      = s_q.mask[0][UART_ONE_RX_EN];
      en[0][SPI_ONE_EVENT_EN]    = s_q.mask[0][SPI_ONE_EVENT_EN];
      en[0][SPI_ONE_ERROR_EN]    = s_q.mask[0][SPI_ONE_ERROR_EN];
      en[0][TIMER_THREE_EN]      = s_q.mask[0][TIMER_THREE_EN];
      en[0][TIMER_TWO_EN]        = s_q.mask[0][TIMER_TWO_EN];
      en[0][TIMER_ONE_EN]        = s_q.mask[0][TIMER_ONE_EN];
      en[0][COMPARE_TWO_EN]      = s_q.mask[0][COMPARE_TWO_EN];
      en[0][CAPTURE_TWO_EN]      = s_q.mask[0][CAPTURE_TWO_EN];
      en[0][COMPARE_ONE_EN]      = s_q.mask[0][COMPARE_ONE_EN];
      en[0][CAPTURE_ONE_EN]      = s_q.mask[0][CAPTURE_ONE_EN];
      en[0][DMA_CH0_DONE_EN]     = s_q.mask[0][DMA_CH0_DONE_EN];
      en[0][EXT_IRQ_ZERO_EN]     = s_q.mask[0][EXT_IRQ_ZERO_EN];
      en[1][UART_TWO_TX_EN]      = s_q.mask[1][UART_TWO_TX_EN];
      en[1][UART_TWO_RX_EN]      = s_q.mask[1][UART_TWO_RX_EN];
      en[1][EXT_IRQ_TWO_EN]      = s_q.mask[1][EXT_IRQ_TWO_EN];
      en[1][EXT_IRQ_ONE_EN]      = s_q.mask[1][EXT_IRQ_ONE_EN];
      en[1][TIMER_FIVE_EN]       = s_q.mask[1][TIMER_FIVE_EN];
      en[1][TIMER_FOUR_EN]       = s_q.mask[1][TIMER_FOUR_EN];
      en[1][COMPARE_FOUR_EN]     = s_q.mask[1][COMPARE_FOUR_EN];
      en[1][COMPARE_THREE_EN]    = s_q.mask[1][COMPARE_THREE_EN];
      en[1][DMA_CH2_DONE_EN]     = s_q.mask[1][DMA_CH2_DONE_EN];
      en[1][CAPTURE_EIGHT_EN]    = s_q.mask[1][CAPTURE_EIGHT_EN];
      en[1][CAPTURE_SEVEN_EN]    = s_q.mask[1][CAPTURE_SEVEN_EN];
      en[1][ADC_TWO_DONE_EN]     = s_q.mask[1][ADC_TWO_DONE_EN];
      en[1][CHANGE_NOTIFY_EN]    = s_q.mask[1][CHANGE_NOTIFY_EN];
      en[1][I2C_ONE_MASTER_EN]   = s_q.mask[1][I2C_ONE_MASTER_EN];
      en[1][I2C_ONE_SLAVE_EN]    = s_q.mask[1][I2C_ONE_SLAVE_EN];
      en[2][TIMER_SIX_EN]        = s_q.mask[2][TIMER_SIX_EN];
      en[2][DMA_CH4_DONE_EN]     = s_q.mask[2][DMA_CH4_DONE_EN];
      en[2][COMPARE_EIGHT_EN]    = s_q.mask[2][COMPARE_EIGHT_EN];
      en[2][COMPARE_SEVEN_EN]    = s_q.mask[2][COMPARE_SEVEN_EN];
      en[2][COMPARE_SIX_EN]      = s_q.mask[2][COMPARE_SIX_EN];
      en[2][COMPARE_FIVE_EN]     = s_q.mask[2][COMPARE_FIVE_EN];
      en[2][CAPTURE_SIX_EN]      = s_q.mask[2][CAPTURE_SIX_EN];
      en[2][CAPTURE_FIVE_EN]     = s_q.mask[2][CAPTURE_FIVE_EN];
      en[2][CAPTURE_FOUR_EN]     = s_q.mask[2][CAPTURE_FOUR_EN];
      en[2][CAPTURE_THREE_EN]    = s_q.mask[2][CAPTURE_THREE_EN];
      en[2][DMA_CH3_DONE_EN]     = s_q.mask[2][DMA_CH3_DONE_EN];
      en[2][CAN_ONE_EVENT_EN]    = s_q.mask[2][CAN_ONE_EVENT_EN];
      en[2][CAN_ONE_RX_READY_EN] = s_q.mask[2][CAN_ONE_RX_READY_EN];
      en[2][SPI_TWO_EVENT_EN]    = s_q.mask[2][SPI_TWO_EVENT_EN];
      en[2][SPI_TWO_ERROR_EN]    = s_q.mask[2][SPI_TWO_ERROR_EN];
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      s_d   = s_q;
      widx  = 2'h0;
      ridx  = 2'h0;
      wbits = MASK_RESET;

      // Write address and data are latched independently, in either order.
      if (axi_req.awvalid && s_q.rsp.awready) begin
         s_d.aw_held     = 1'b1;
         s_d.aw_addr     = axi_req.awaddr;
         s_d.rsp.awready = 1'b0;
      end
      if (axi_req.wvalid && s_q.rsp.wready) begin
         s_d.w_held     = 1'b1;
         s_d.w_data     = axi_req.wdata;
         s_d.w_strb     = axi_req.wstrb;
         s_d.rsp.wready = 1'b0;
      end
      if (s_q.rsp.bvalid && axi_req.bready) begin
         s_d.rsp.bvalid  = 1'b0;
         s_d.rsp.awready = 1'b1;
         s_d.rsp.wready  = 1'b1;
      end

      if (s_q.aw_held && s_q.w_held && !s_q.rsp.bvalid) begin
         widx = decode(s_q.aw_addr);
         // Unmapped writes are answered with an error rather than dropped silently.
         if (widx == 2'h3) begin
            s_d.rsp.bresp = RESP_SLVERR;
         end else begin
            s_d.rsp.bresp = RESP_OKAY;
            wbits = impl_bits(widx);
            if (s_q.w_strb[0]) begin
               s_d.mask[widx][7:0] = s_q.w_data[7:0] & wbits[7:0];
            end
            if (s_q.w_strb[1]) begin
               s_d.mask[widx][15:8] = s_q.w_data[15:8] & wbits[15:8];
            end
         end
         s_d.aw_held    = 1'b0;
         s_d.w_held     = 1'b0;
         s_d.rsp.bvalid = 1'b1;
      end

      if (s_q.rsp.rvalid && axi_req.rready) begin
         s_d.rsp.rvalid  = 1'b0;
         s_d.rsp.arready = 1'b1;
      end
      if (axi_req.arvalid && s_q.rsp.arready) begin
         ridx = decode(axi_req.araddr);
         s_d.rsp.arready = 1'b0;
         s_d.rsp.rvalid  = 1'b1;
         if (ridx == 2'h3) begin
            s_d.rsp.rdata = 32'h0000_0000;
            s_d.rsp.rresp = RESP_SLVERR;
         end else begin
            // Upper half-word and unimplemented bits always read zero.
            s_d.rsp.rdata = {16'h0000, s_q.mask[ridx] & impl_bits(ridx)};
            s_d.rsp.rresp = RESP_OKAY;
         end
      end

      // Requests are registered so the outputs stay glitch free; one cycle of latency.
      for (int r = 0; r < NUM_REGS; r++) begin
         for (int b = 0; b < REG_W; b++) begin
            s_d.req[r][b] = src_flag[r][b] && en[r][b]
                            && (src_prio[r][b] != PRIO_OFF);
         end
      end

      if (!aresetn) begin
         s_d             = '0;
         s_d.mask        = {NUM_REGS{MASK_RESET}};
         s_d.rsp.awready = 1'b1;
         s_d.rsp.wready  = 1'b1;
         s_d.rsp.arready = 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      s_q <= s_d;
   end

   assign axi_rsp  = s_q.rsp;
   assign irq_req  = s_q.req;
   assign mask_out = s_q.mask;

endmodule : iemb_mask_bank

//--- iemb_pkg.sv
/*
 Package for the interrupt enable mask bank: register offsets, implemented-bit masks,
 field positions, bus response codes and the carrier structs.
 Assumes a 32-bit AXI4-Lite register bus and 16-bit mask registers in the low bits.
*/
// Operation
// - An enable bit at one passes its source's request; at zero blocks it.
// - All implemented enable bits reset to zero; every source starts masked.
// - Bit 15 of mask 0, bit 2 of mask 1, bit 13 of mask 2 read zero.
// - Implemented enable bits are read/write and read back the last written value.
// - Mask 0 bit 14 gates DMA channel 1 done; bit 13 gates ADC one done.
// - Mask 0 bit 12 gates UART one transmit; bit 11 gates UART one receive.
// - Mask 0 bit 10 gates SPI one event; bit 9 gates SPI one error.
// - Mask 0 bit 8 gates timer three, bit 7 timer two, bit 3 timer one.
// - Mask 0 bits 6,5 gate compare/capture two; bits 2,1 compare/capture one.
// - Mask 0 bit 4 gates DMA channel 0 done; bit 0 external interrupt zero.
// - Mask 1 bit 15 gates UART two transmit; bit 14 UART two receive.
// - Mask 1 bit 13 gates external interrupt two; bit 4 external interrupt one.
// - Mask 1 bit 12 gates timer five; bit 11 gates timer four.
// - Mask 1 bits 10,9 gate compare four, three; bit 8 DMA channel 2.
// - Mask 1 bits 7,6 gate capture eight, seven; bit 5 ADC two done.
// - Mask 1 bit 3 change notify; bit 1 I2C one master; bit 0 slave.
// - Mask 2 bit 15 gates timer six; bit 14 DMA channel 4 done.
// - Mask 2 bits 12 to 9 gate compare channels eight to five.
// - Mask 2 bits 8 to 5 gate capture six to three; bit 4 DMA three.
// - Mask 2 bit 3 gates CAN one event; bit 2 CAN one receive ready.
// - Mask 2 bit 1 gates SPI two event; bit 0 SPI two error.
// - Each source's flag input is gated by its enable bit toward the processor.
// - Each source has a 3-bit priority; zero disables it regardless of enable.
package iemb_pkg;

   localparam int          NUM_REGS  = 3;
   localparam int          REG_W     = 16;
   localparam int          PRIO_W    = 3;
   localparam int          ADDR_W    = 4;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] MASK0_ADDR = 4'h0;
   localparam logic [ADDR_W-1:0] MASK1_ADDR = 4'h4;
   localparam logic [ADDR_W-1:0] MASK2_ADDR = 4'h8;

   // Implemented bits of each mask register; zero marks an unimplemented position.
   localparam logic [REG_W-1:0] MASK0_IMPL = 16'h7FFF;
   localparam logic [REG_W-1:0] MASK1_IMPL = 16'hFFFB;
   localparam logic [REG_W-1:0] MASK2_IMPL = 16'hDFFF;
   localparam logic [REG_W-1:0] MASK_RESET = 16'h0000;

   localparam logic [PRIO_W-1:0] PRIO_OFF   = 3'h0;
   localparam logic [1:0]        RESP_OKAY  = 2'h0;
   localparam logic [1:0]        RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------------
   // Field positions inside the mask registers
   // ----------------------------------------------------------------------
   localparam int DMA_CH1_DONE_EN     = 14;
   localparam int ADC_ONE_DONE_EN     = 13;
   localparam int UART_ONE_TX_EN      = 12;
   localparam int UART_ONE_RX_EN      = 11;
   localparam int SPI_ONE_EVENT_EN    = 10;
   localparam int SPI_ONE_ERROR_EN    = 9;
   localparam int TIMER_THREE_EN      = 8;
   localparam int TIMER_TWO_EN        = 7;
   localparam int COMPARE_TWO_EN      = 6;
   localparam int CAPTURE_TWO_EN      = 5;
   localparam int DMA_CH0_DONE_EN     = 4;
   localparam int TIMER_ONE_EN        = 3;
   localparam int COMPARE_ONE_EN      = 2;
   localparam int CAPTURE_ONE_EN      = 1;
   localparam int EXT_IRQ_ZERO_EN     = 0;

   localparam int UART_TWO_TX_EN      = 15;
   localparam int UART_TWO_RX_EN      = 14;
   localparam int EXT_IRQ_TWO_EN      = 13;
   localparam int TIMER_FIVE_EN       = 12;
   localparam int TIMER_FOUR_EN       = 11;
   localparam int COMPARE_FOUR_EN     = 10;
   localparam int COMPARE_THREE_EN    = 9;
   localparam int DMA_CH2_DONE_EN     = 8;
   localparam int CAPTURE_EIGHT_EN    = 7;
   localparam int CAPTURE_SEVEN_EN    = 6;
   localparam int ADC_TWO_DONE_EN     = 5;
   localparam int EXT_IRQ_ONE_EN      = 4;
   localparam int CHANGE_NOTIFY_EN    = 3;
   localparam int I2C_ONE_MASTER_EN   = 1;
   localparam int I2C_ONE_SLAVE_EN    = 0;

   localparam int TIMER_SIX_EN        = 15;
   localparam int DMA_CH4_DONE_EN     = 14;
   localparam int COMPARE_EIGHT_EN    = 12;
   localparam int COMPARE_SEVEN_EN    = 11;
   localparam int COMPARE_SIX_EN      = 10;
   localparam int COMPARE_FIVE_EN     = 9;
   localparam int CAPTURE_SIX_EN      = 8;
   localparam int CAPTURE_FIVE_EN     = 7;
   localparam int CAPTURE_FOUR_EN     = 6;
   localparam int CAPTURE_THREE_EN    = 5;
   localparam int DMA_CH3_DONE_EN     = 4;
   localparam int CAN_ONE_EVENT_EN    = 3;
   localparam int CAN_ONE_RX_READY_EN = 2;
   localparam int SPI_TWO_EVENT_EN    = 1;
   localparam int SPI_TWO_ERROR_EN    = 0;

   // ----------------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------------
   typedef logic [NUM_REGS-1:0][REG_W-1:0]             iemb_vec_t;
   typedef logic [NUM_REGS-1:0][REG_W-1:0][PRIO_W-1:0] iemb_prio_t;

   typedef struct packed {
      logic [ADDR_W-1:0] awaddr;
      logic              awvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              wvalid;
      logic              bready;
      logic [ADDR_W-1:0] araddr;
      logic              arvalid;
      logic              rready;
   } iemb_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } iemb_axi_rsp_t;

   typedef struct packed {
      iemb_vec_t         mask;
      iemb_vec_t         req;
      logic              aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_held;
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      iemb_axi_rsp_t     rsp;
   } iemb_state_t;

   function automatic logic [REG_W-1:0] impl_bits(input logic [1:0] idx);
      case (idx)
         2'h0:    impl_bits = MASK0_IMPL;
         2'h1:    impl_bits = MASK1_IMPL;
         2'h2:    impl_bits = MASK2_IMPL;
         default: impl_bits = MASK_RESET;
      endcase
   endfunction : impl_bits

   // Returns the register index for a byte address, or 3 when nothing is mapped there.
   function automatic logic [1:0] decode(input logic [ADDR_W-1:0] addr);
      case (addr)
         MASK0_ADDR: decode = 2'h0;
         MASK1_ADDR: decode = 2'h1;
         MASK2_ADDR: decode = 2'h2;
         default:    decode = 2'h3;
      endcase
   endfunction : decode

endpackage : iemb_pkg

//--- iemb_mask_bank_properties.sv
/*
 Checker for the interrupt enable mask bank, watching the top module's ports only.
 Assumes one clock, aclk, and a synchronous active-low reset, aresetn.
*/
`timescale 1ns/100ps
module iemb_mask_bank_properties (
   input wire logic                    aclk,
   input wire logic                    aresetn,
   input wire iemb_pkg::iemb_axi_req_t axi_req,
   input wire iemb_pkg::iemb_axi_rsp_t axi_rsp,
   input wire iemb_pkg::iemb_vec_t     src_flag,
   input wire iemb_pkg::iemb_prio_t    src_prio,
   input wire iemb_pkg::iemb_vec_t     irq_req,
   input wire iemb_pkg::iemb_vec_t     mask_out
);
   import iemb_pkg::*;
   localparam iemb_vec_t IMPL = {MASK2_IMPL, MASK1_IMPL, MASK0_IMPL};
   iemb_vec_t prio_nz;
   always_comb begin
      for (int r = 0; r < NUM_REGS; r++) begin
         for (int b = 0; b < REG_W; b++) begin
            prio_nz[r][b] = src_prio[r][b] != PRIO_OFF;
         end
      end
   end
   // ----------------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_reset_clears: assert property (disable iff (1'b0) !aresetn |=> mask_out == '0 && irq_req == '0)
      else $error("Reset left a mask or request set");
   a_gate_request: assert property (1'b1 |=> irq_req == $past(src_flag & mask_out & prio_nz))
      else $error("Request output does not follow flag, mask and priority");
   a_unimpl_zero: assert property ((mask_out & ~IMPL) == '0 && (irq_req & ~IMPL) == '0)
      else $error("Unimplemented position is set");
   a_mask_on_write: assert property (!$stable(mask_out) |-> $rose(axi_rsp.bvalid))
      else $error("Mask changed without a write response");
   a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
      |=> ##1 axi_rsp.bvalid)
      else $error("Write response late");
   a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
      else $error("Read answer late");
   a_read_upper: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:16] == 16'h0000)
      else $error("Upper read bits not zero");
   a_write_release: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid && axi_rsp.awready)
      else $error("Write response not released");
   a_read_release: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid && axi_rsp.arready)
      else $error("Read response not released");
   c_write_done: cover property (axi_rsp.bvalid && axi_req.bready);
   c_read_error: cover property (axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR);
   c_request_out: cover property (irq_req != '0);
endmodule : iemb_mask_bank_properties
bind iemb_mask_bank iemb_mask_bank_properties chk_u (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
   .axi_rsp(axi_rsp), .src_flag(src_flag), .src_prio(src_prio), .irq_req(irq_req), .mask_out(mask_out));

//--- tb_top.sv
/*
 Self-checking bench for the interrupt enable mask bank.
 Assumes the package, the design and the bound checker are compiled before it.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module tb_top;
   import iemb_pkg::*;
   typedef struct packed {logic [3:0] a; logic [1:0] i; logic [15:0] d; logic [15:0] e;} iemb_row_t;
   localparam iemb_row_t ROWS [6] = '{'{MASK0_ADDR, 2'h0, 16'hFFFF, 16'h7FFF},
                                      '{MASK1_ADDR, 2'h1, 16'hFFFF, 16'hFFFB},
                                      '{MASK2_ADDR, 2'h2, 16'hFFFF, 16'hDFFF},
                                      '{MASK0_ADDR, 2'h0, 16'h5555, 16'h5555},
                                      '{MASK1_ADDR, 2'h1, 16'hAAAA, 16'hAAAA},
                                      '{MASK2_ADDR, 2'h2, 16'h2000, 16'h0000}};
   logic          aclk;
   logic          aresetn;
   iemb_axi_req_t req;
   iemb_axi_rsp_t rsp;
   iemb_vec_t     src_flag;
   iemb_prio_t    src_prio;
   iemb_vec_t     irq_req;
   iemb_vec_t     mask_out;
   int            err_count;
   int            compares;
   logic [31:0]   rd;
   logic [1:0]    rs;
   iemb_mask_bank dut_u (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .src_flag(src_flag),
      .src_prio(src_prio), .irq_req(irq_req), .mask_out(mask_out));
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // ----------------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------------
   // Each task first lets an edge pass, so a strobe dropped by the last call is never raised in the same step.
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      @(posedge aclk);
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= s;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
         if (req.bready && rsp.bvalid) begin
            r = rsp.bresp;
            req.bready <= 1'b0;
            break;
         end
      end
   endtask : axi_write
   task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
         if (req.rready && rsp.rvalid) begin
            d = rsp.rdata;
            r = rsp.rresp;
            req.rready <= 1'b0;
            break;
         end
      end
   endtask : axi_read
   task automatic close_out();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (2000) @(posedge aclk);
      err_count++;
      close_out();
   end
   initial begin
      req = '0;
      src_flag = '0;
      src_prio = '0;
      aresetn = 1'b0;
      err_count = 0;
      compares = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < NUM_REGS; i++) begin
         axi_read(4'(i * 4), rd, rs);
         `CHK("reset value", 32'h0000_0000, rd)
      end
      src_flag <= '1;
      src_prio <= {48{3'h1}};
      foreach (ROWS[k]) begin
         axi_write(ROWS[k].a, {16'h0000, ROWS[k].d}, 4'h3, rs);
         `CHK("write resp", RESP_OKAY, rs)
         axi_read(ROWS[k].a, rd, rs);
         `CHK("read back", {16'h0000, ROWS[k].e}, rd)
         `CHK("mask out", ROWS[k].e, mask_out[ROWS[k].i])
         `CHK("gated request", ROWS[k].e, irq_req[ROWS[k].i])
      end
      src_prio[0][0] <= PRIO_OFF;
      src_flag[1] <= 16'h00FF;
      repeat (2) @(posedge aclk);
      `CHK("zero priority", 16'h5554, irq_req[0])
      `CHK("flag low", 16'h00AA, irq_req[1])
      axi_write(MASK1_ADDR, 32'h0000_FF00, 4'h1, rs);
      `CHK("byte strobe resp", RESP_OKAY, rs)
      axi_read(MASK1_ADDR, rd, rs);
      `CHK("byte strobe", 32'h0000_AA00, rd)
      axi_write(4'hC, 32'h0000_FFFF, 4'h3, rs);
      `CHK("unmapped write resp", RESP_SLVERR, rs)
      axi_read(4'hC, rd, rs);
      `CHK("unmapped read resp", RESP_SLVERR, rs)
      `CHK("unmapped read data", 32'h0000_0000, rd)
      `CHK("masks kept", 48'h0000_AA00_5555, mask_out)
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK("second reset masks", 48'h0, mask_out)
      `CHK("second reset requests", 48'h0, irq_req)
      close_out();
   end
endmodule : tb_top
